// >>> src/irq_pkg.sv
// Shared constants and types for the interrupt controller and its CPU end
package irq_pkg;
	localparam int NSRC   = 4;          // External interrupt lines
	localparam int SEL_W  = 2;          // Width of a source index
	localparam int PRIO_W = 2;          // Width of a priority level
	localparam int VEC_W  = 3;          // Width of a vector code
	localparam int SP_W   = 3;          // Width of the stack pointer
	localparam int OP_W   = 3;          // Width of a command code

	// Vector code that sends the CPU to the reset entry
	localparam logic [VEC_W-1:0] VEC_RESET = 3'h4;

	// Command codes on the CPU end's user port
	localparam logic [OP_W-1:0] OP_CFG = 3'h0;  // Port configuration write
	localparam logic [OP_W-1:0] OP_CLR = 3'h1;  // Clear a pending flag
	localparam logic [OP_W-1:0] OP_EN  = 3'h2;  // Load the enable mask
	localparam logic [OP_W-1:0] OP_POP = 3'h3;  // Condition-code pop
	localparam logic [OP_W-1:0] OP_SIM = 3'h4;  // Mask set instruction
	localparam logic [OP_W-1:0] OP_RIM = 3'h5;  // Mask clear instruction

	// Frame layout: A, X, then the condition codes, pushed last
	localparam logic [1:0]      FRAME_LAST = 2'h2;
	localparam logic [SP_W-1:0] FRAME_SIZE = 3'h3;

	// Values after reset
	localparam logic            IMASK_RST = 1'b1;
	localparam logic [NSRC-1:0] EN_RST    = 4'h0;
	localparam logic [SP_W-1:0] SP_RST    = 3'h0;

	typedef logic [NSRC-1:0]        src_mask_t;
	typedef logic [SEL_W-1:0]       src_sel_t;
	typedef logic [VEC_W-1:0]       vec_t;
	typedef logic [NSRC*PRIO_W-1:0] prio_map_t;
endpackage

// >>> src/irq_link_if.sv
// Link between the interrupt controller and the CPU that services it
`timescale 1ns/1ns
`default_nettype none
interface irq_link_if;
	import irq_pkg::*;
	logic      cfg_access;  // Port direction or option register access, pulse
	logic      flag_clr;    // Pending flag clear, pulse
	src_sel_t  flag_sel;    // Source whose flag is cleared
	logic      en_wr;       // Enable mask load, pulse
	src_mask_t en_val;      // New enable mask
	logic      imask;       // Global interrupt mask bit, level
	logic      cc_pop;      // Condition-code pop executing, pulse
	logic      vec_fetch;   // Vector fetch, pulse
	logic      interrupt_return;        // Hardware interrupt return, pulse
	logic      irq_req;     // Request to the CPU, level
	logic      vec_valid;   // Vector answer, pulse
	vec_t      vec;         // Vector code
	logic      spur_reset;  // Unwanted reset, pulse
	src_mask_t pin_level;   // Synchronised pin levels
	src_mask_t sense;       // Rising (1) or falling (0) edge per pin

	modport dev_mp (
		input  cfg_access, flag_clr, flag_sel, en_wr, en_val, imask, cc_pop,
		input  vec_fetch, interrupt_return,
		output irq_req, vec_valid, vec, spur_reset, pin_level, sense
	);
	modport cpu_mp (
		output cfg_access, flag_clr, flag_sel, en_wr, en_val, imask, cc_pop,
		output vec_fetch, interrupt_return,
		input  irq_req, vec_valid, vec, spur_reset, pin_level, sense
	);
endinterface
`default_nettype wire

// >>> src/irq_dev_end.sv
// Interrupt controller end: edge detection, pending flags, vector choice
`timescale 1ns/1ns
`default_nettype none
module irq_dev_end (
	input  wire logic              core_clk_i,
	input  wire logic              resetn_i,
	irq_link_if.dev_mp             link,
	input  wire irq_pkg::src_mask_t pin_i,
	input  wire irq_pkg::src_mask_t rise_i,
	input  wire irq_pkg::prio_map_t prio_i,
	input  wire logic              nest_i,
	output logic                   unwanted_reset_o,
	output irq_pkg::src_mask_t     pending_o
);
	import irq_pkg::*;

	src_mask_t sync1_reg;     // First synchroniser stage
	src_mask_t sync2_reg;     // Second synchroniser stage
	src_mask_t prev_reg;      // Previous synchronised level
	src_mask_t edge_hit;      // Qualified edge per pin
	src_mask_t pend_reg;      // Pending flags
	src_mask_t en_reg;        // Per-source enable mask
	src_mask_t svc_reg;       // Sources in service
	src_mask_t clr_vec;       // Decoded flag clear
	src_mask_t sense_reg;     // Registered edge sensitivity
	logic      lost_reg;      // Source lost during a pop
	logic      lost_now;      // Loss happening this cycle
	logic      vld_reg;       // Vector answer strobe
	vec_t      vec_reg;       // Vector answer
	logic      unw_reg;       // Unwanted reset pulse
	logic      req_any;       // Some enabled flag pending
	src_sel_t  req_id;        // Best pending source
	logic      svc_any;       // Some routine in service
	src_sel_t  svc_id;        // Highest routine in service
	logic      active;        // Request active on the cleared source
	logic      safe_ctx;      // Clearing context cannot misfire

	// Highest-priority member of a mask; the lower index wins a tie
	function automatic logic [SEL_W:0] pick(input src_mask_t m, input prio_map_t p);
		logic             found;
		src_sel_t         idx;
		logic [PRIO_W-1:0] best;
		found = 1'b0;
		idx   = '0;
		best  = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (m[i] && (!found || p[i*PRIO_W +: PRIO_W] >= best)) begin
				found = 1'b1;
				idx   = SEL_W'(i);
				best  = p[i*PRIO_W +: PRIO_W];
			end
		end
		return {found, idx};
	endfunction

	function automatic logic [PRIO_W-1:0] prio_of(input src_sel_t s, input prio_map_t p);
		return p[s*PRIO_W +: PRIO_W];
	endfunction

	// Two stages before any logic sees the pins, then one for the edge
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
			sense_reg <= '0;
		end else begin
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
			sense_reg <= rise_i;
		end
	end

	// Edges are dropped during a port configuration access cycle
	generate
		for (genvar g = 0; g < NSRC; g++) begin : g_edge
			assign edge_hit[g] = ~link.cfg_access & (rise_i[g] ?
				(sync2_reg[g] & ~prev_reg[g]) : (~sync2_reg[g] & prev_reg[g]));
			assign clr_vec[g]  = link.flag_clr & (link.flag_sel == SEL_W'(g));
		end
	endgenerate

	assign {req_any, req_id} = pick(pend_reg & en_reg, prio_i);
	assign {svc_any, svc_id} = pick(svc_reg, prio_i);

	// Pending flags; a new edge beats a clear in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			pend_reg <= '0;
		end else begin
			pend_reg <= edge_hit | (pend_reg & ~clr_vec);
		end
	end

	// Enable mask; clearing it has no path to the reset output
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			en_reg <= EN_RST;
		end else if (link.en_wr) begin
			en_reg <= link.en_val;
		end
	end

	// An edge during an unmasked pop leaves the source unknown
	assign lost_now = (|edge_hit) & link.cc_pop & ~link.imask;

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			lost_reg <= 1'b0;
		end else if (lost_now) begin
			lost_reg <= 1'b1;
		end else if (link.vec_fetch) begin
			lost_reg <= 1'b0;
		end
	end

	// Vector answer one cycle after the fetch
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			vld_reg <= 1'b0;
			vec_reg <= '0;
		end else begin
			vld_reg <= link.vec_fetch;
			if (link.vec_fetch) begin
				if (lost_reg || lost_now || !req_any) begin
					vec_reg <= VEC_RESET;
				end else begin
					vec_reg <= VEC_W'(req_id);
				end
			end
		end
	end

	// In-service set on a fetch, highest one dropped on return
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			svc_reg <= '0;
		end else begin
			if (link.interrupt_return && svc_any) begin
				svc_reg[svc_id] <= 1'b0;
			end
			if (link.vec_fetch && req_any && !lost_reg && !lost_now) begin
				svc_reg[req_id] <= 1'b1;
			end
		end
	end

	// A routine of equal or higher level makes a clear safe
	assign safe_ctx = ~en_reg[link.flag_sel] | (svc_any & (~nest_i |
		prio_of(svc_id, prio_i) >= prio_of(link.flag_sel, prio_i)));
	assign active = edge_hit[link.flag_sel] |
		(pend_reg[link.flag_sel] & en_reg[link.flag_sel]);

	// Clearing a live request with the mask clear, outside a safe context, misfires
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			unw_reg <= 1'b0;
		end else begin
			unw_reg <= link.flag_clr & active & ~link.imask & ~safe_ctx;
		end
	end

	// Masked interrupts, or a lower level while nested, stay waiting
	assign link.irq_req    = req_any & ~link.imask &
		(~svc_any | (nest_i & prio_of(req_id, prio_i) > prio_of(svc_id, prio_i)));
	assign link.vec_valid  = vld_reg;
	assign link.vec        = vec_reg;
	assign link.spur_reset = unw_reg;
	assign link.pin_level  = sync2_reg;
	assign link.sense      = sense_reg;
	assign unwanted_reset_o = unw_reg;
	assign pending_o        = pend_reg;
endmodule
`default_nettype wire

// >>> src/irq_cpu_end.sv
// CPU end: safe mask, clear, pop and port-write sequences, interrupt entry
`timescale 1ns/1ns
`default_nettype none
module irq_cpu_end (
	input  wire logic               core_clk_i,
	input  wire logic               resetn_i,
	irq_link_if.cpu_mp              link,
	input  wire logic               cmd_valid_i,
	input  wire logic [2:0]         cmd_op_i,
	input  wire irq_pkg::src_sel_t  cmd_sel_i,
	input  wire irq_pkg::src_mask_t cmd_data_i,
	output logic                    cmd_ready_o,
	output logic                    done_o,
	output logic                    missed_o,
	output logic                    svc_o,
	output irq_pkg::src_sel_t       svc_src_o,
	output logic                    reset_fetch_o,
	output logic                    imask_o,
	output logic                    sema_o
);
	import irq_pkg::*;

	typedef enum logic [14:0] {
		ST_IDLE     = 15'h0001,  // Waiting for a command or a request
		ST_CFG_ACC  = 15'h0002,  // Port configuration access
		ST_CFG_POST = 15'h0004,  // Sample the level after the write
		ST_CFG_CHK  = 15'h0008,  // Compare levels, test the semaphore
		ST_CFG_OUT  = 15'h0010,  // Drop the semaphore, finish
		ST_PUSH     = 15'h0020,  // Build the three-entry frame
		ST_ISR      = 15'h0040,  // Routine body
		ST_INTERRUPT_RETURN     = 15'h0080,  // Unwind the frame
		ST_VEC      = 15'h0100,  // Fetch the vector
		ST_VWAIT    = 15'h0200,  // Wait for the vector
		ST_CLR_SET  = 15'h0400,  // Push codes, set the mask
		ST_CLR_DO   = 15'h0800,  // Clear the flag under the mask
		ST_POP_SET  = 15'h1000,  // Set the mask ahead of a pop
		ST_POP_DO   = 15'h2000,  // Pop the condition codes
		ST_EN       = 15'h4000   // Load the enable mask
	} cpu_state_t;

	cpu_state_t      state_reg;     // Sequencer state
	cpu_state_t      ret_reg;       // State to resume after a routine
	logic            imask_reg;     // Global interrupt mask bit
	logic            sema_reg;      // Missed-edge semaphore
	logic            masked_reg;    // Port write began with the mask set
	logic            before_reg;    // Pin level before the write
	logic            after_reg;     // Pin level after the write
	logic            hw_reg;        // Routine entered by hardware
	src_sel_t        sel_reg;       // Source named by the command
	src_sel_t        src_reg;       // Source of the running routine
	src_mask_t       data_reg;      // Enable mask to load
	logic [1:0]      push_cnt_reg;  // Frame entry being pushed
	logic [SP_W-1:0] sp_reg;        // Stack depth
	logic [7:0]      ccstk_reg;     // Saved mask bits, one per depth
	logic            done_reg;      // Command finished pulse
	logic            missed_reg;    // Missed edge recovered pulse
	logic            svc_reg;       // Routine ran pulse
	logic            rst_reg;       // Reset vector taken pulse
	logic            accept;        // Command taken this cycle
	logic            take_irq;      // Interrupt entry this cycle
	logic            edge_seen;     // Level change matching the sense
	logic            is_reset;      // Vector answer is the reset vector

	assign accept   = (state_reg == ST_IDLE) & cmd_valid_i & ~link.irq_req;
	// Only the idle, post-write and level-check waits may be interrupted; the device
	// already folds the mask bit into its request
	assign take_irq = link.irq_req & ((state_reg == ST_IDLE) |
		(state_reg == ST_CFG_POST) | (state_reg == ST_CFG_CHK));
	// Level change in the programmed direction only
	assign edge_seen = link.sense[sel_reg] ? (~before_reg & after_reg) :
		(before_reg & ~after_reg);
	assign is_reset  = link.vec == VEC_RESET;

	// Sequencer
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			state_reg    <= ST_IDLE;
			ret_reg      <= ST_IDLE;
			masked_reg   <= 1'b0;
			before_reg   <= 1'b0;
			after_reg    <= 1'b0;
			hw_reg       <= 1'b0;
			sel_reg      <= '0;
			src_reg      <= '0;
			data_reg     <= '0;
			push_cnt_reg <= '0;
		end else if (take_irq) begin
			ret_reg   <= state_reg;
			state_reg <= ST_VEC;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (accept) begin
						sel_reg    <= cmd_sel_i;
						data_reg   <= cmd_data_i;
						before_reg <= link.pin_level[cmd_sel_i];
						masked_reg <= imask_reg;
						unique case (cmd_op_i)
							OP_CFG:  state_reg <= ST_CFG_ACC;
							OP_CLR:  state_reg <= ST_CLR_SET;
							OP_EN:   state_reg <= ST_EN;
							OP_POP:  state_reg <= ST_POP_SET;
							default: state_reg <= ST_IDLE;
						endcase
					end
				end
				ST_CFG_ACC:  state_reg <= ST_CFG_POST;
				ST_CFG_POST: begin
					after_reg <= link.pin_level[sel_reg];
					state_reg <= ST_CFG_CHK;
				end
				ST_CFG_CHK: begin
					if (masked_reg) begin
						// Stay one more pass, now unmasked, so a late
						// hardware entry can still claim the semaphore
						masked_reg <= 1'b0;
					end else if (edge_seen && sema_reg) begin
						hw_reg    <= 1'b0;
						src_reg   <= sel_reg;
						ret_reg   <= ST_CFG_OUT;
						state_reg <= ST_PUSH;
					end else begin
						state_reg <= ST_CFG_OUT;
					end
				end
				ST_CFG_OUT:  state_reg <= ST_IDLE;
				ST_PUSH: begin
					if (push_cnt_reg == FRAME_LAST) begin
						push_cnt_reg <= '0;
						state_reg    <= ST_ISR;
					end else begin
						push_cnt_reg <= push_cnt_reg + 2'h1;
					end
				end
				ST_ISR:      state_reg <= ST_INTERRUPT_RETURN;
				ST_INTERRUPT_RETURN:     state_reg <= ret_reg;
				ST_VEC:      state_reg <= ST_VWAIT;
				ST_VWAIT: begin
					if (link.vec_valid) begin
						if (is_reset) begin
							state_reg <= ST_IDLE;
						end else begin
							hw_reg    <= 1'b1;
							src_reg   <= link.vec[SEL_W-1:0];
							state_reg <= ST_PUSH;
						end
					end
				end
				ST_CLR_SET:  state_reg <= ST_CLR_DO;
				ST_CLR_DO:   state_reg <= ST_POP_DO;
				ST_POP_SET:  state_reg <= ST_POP_DO;
				ST_POP_DO:   state_reg <= ST_IDLE;
				ST_EN:       state_reg <= ST_IDLE;
			endcase
		end
	end

	// Global mask bit; the pop restores whatever was saved with it
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			imask_reg <= IMASK_RST;
		end else if (state_reg == ST_VWAIT && link.vec_valid && is_reset) begin
			imask_reg <= IMASK_RST;
		end else if (accept && cmd_op_i == OP_SIM) begin
			imask_reg <= 1'b1;
		end else if (accept && cmd_op_i == OP_RIM) begin
			imask_reg <= 1'b0;
		end else if (state_reg == ST_CFG_CHK && masked_reg) begin
			imask_reg <= 1'b0;
		end else if (state_reg == ST_PUSH && push_cnt_reg == FRAME_LAST && hw_reg) begin
			imask_reg <= 1'b1;
		end else if (state_reg == ST_CLR_SET || state_reg == ST_POP_SET) begin
			imask_reg <= 1'b1;
		end else if (state_reg == ST_INTERRUPT_RETURN || state_reg == ST_POP_DO) begin
			imask_reg <= ccstk_reg[sp_reg - 3'h1];
		end
	end

	// Semaphore: raised around a port write, dropped by any routine
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sema_reg <= 1'b0;
		end else if (state_reg == ST_ISR || state_reg == ST_CFG_OUT) begin
			sema_reg <= 1'b0;
		end else if (accept && cmd_op_i == OP_CFG && !imask_reg) begin
			sema_reg <= 1'b1;
		end else if (state_reg == ST_CFG_CHK && masked_reg && edge_seen) begin
			sema_reg <= 1'b1;
		end
	end

	// Stack: three entries per frame, the mask bit rides with the last
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sp_reg    <= SP_RST;
			ccstk_reg <= '0;
		end else if (state_reg == ST_VWAIT && link.vec_valid && is_reset) begin
			sp_reg <= SP_RST;
		end else if (state_reg == ST_PUSH || state_reg == ST_CLR_SET) begin
			if (state_reg == ST_CLR_SET || push_cnt_reg == FRAME_LAST) begin
				ccstk_reg[sp_reg] <= imask_reg;
			end
			sp_reg <= sp_reg + 3'h1;
		end else if (state_reg == ST_INTERRUPT_RETURN) begin
			sp_reg <= sp_reg - FRAME_SIZE;
		end else if (state_reg == ST_POP_DO) begin
			sp_reg <= sp_reg - 3'h1;
		end
	end

	// Status pulses towards the user side
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			done_reg   <= 1'b0;
			missed_reg <= 1'b0;
			svc_reg    <= 1'b0;
			rst_reg    <= 1'b0;
			svc_src_o  <= '0;
		end else begin
			done_reg <= (accept && cmd_op_i != OP_CFG && cmd_op_i != OP_CLR &&
				cmd_op_i != OP_EN && cmd_op_i != OP_POP) ||
				state_reg == ST_CFG_OUT || state_reg == ST_POP_DO ||
				state_reg == ST_EN;
			missed_reg <= state_reg == ST_CFG_CHK && !masked_reg && !take_irq &&
				edge_seen && sema_reg;
			svc_reg <= state_reg == ST_ISR;
			rst_reg <= state_reg == ST_VWAIT && link.vec_valid && is_reset;
			if (state_reg == ST_ISR) begin
				svc_src_o <= src_reg;
			end
		end
	end

	// Strobes; a flag is cleared only inside its own hardware routine
	// or under the mask, never in a software-called routine
	assign link.cfg_access = state_reg == ST_CFG_ACC;
	assign link.flag_clr   = (state_reg == ST_ISR && hw_reg) ||
		state_reg == ST_CLR_DO;
	assign link.flag_sel   = (state_reg == ST_ISR) ? src_reg : sel_reg;
	assign link.en_wr      = state_reg == ST_EN;
	assign link.en_val     = data_reg;
	assign link.imask      = imask_reg;
	assign link.cc_pop     = state_reg == ST_POP_DO;
	assign link.vec_fetch  = state_reg == ST_VEC;
	assign link.interrupt_return       = state_reg == ST_INTERRUPT_RETURN && hw_reg;

	assign cmd_ready_o   = (state_reg == ST_IDLE) & ~link.irq_req;
	assign done_o        = done_reg;
	assign missed_o      = missed_reg;
	assign svc_o         = svc_reg;
	assign reset_fetch_o = rst_reg;
	assign imask_o       = imask_reg;
	assign sema_o        = sema_reg;
endmodule
`default_nettype wire

// >>> tb/irq_link_chk.sv
// Checker for the link between the interrupt controller and the CPU end
`timescale 1ns/1ns
`default_nettype none
module irq_link_chk
	import irq_pkg::*;
(
	input wire logic core_clk_i,  // Core clock
	input wire logic resetn_i,    // Sync reset, active low
	input wire logic cfg_access,  // Port configuration access pulse
	input wire logic flag_clr,    // Pending flag clear pulse
	input wire logic imask,       // Global interrupt mask
	input wire logic cc_pop,      // Condition-code pop pulse
	input wire logic vec_fetch,   // Vector fetch pulse
	input wire logic irq_req,     // Request to the CPU
	input wire logic vec_valid,   // Vector answer pulse
	input wire vec_t vec,         // Vector code
	input wire logic spur_reset   // Unwanted reset pulse
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// A pop with the mask clear would risk the reset vector
	property p_pop_masked;
		cc_pop |-> imask;
	endproperty
	a_pop_masked: assert property (p_pop_masked)
		else $error("condition-code pop seen with mask clear");

	// Flag clears only happen under the mask
	property p_clr_masked;
		flag_clr |-> imask;
	endproperty
	a_clr_masked: assert property (p_clr_masked)
		else $error("flag clear seen with mask clear");

	// Only an unmasked flag clear may cause an unwanted reset
	property p_spur_cause;
		spur_reset |-> $past(flag_clr) && !$past(imask);
	endproperty
	a_spur_cause: assert property (p_spur_cause)
		else $error("unwanted reset without an unmasked flag clear");

	// Vector answer exactly one cycle after the fetch, one cycle long
	property p_vec_answer;
		vec_fetch |=> vec_valid ##1 !vec_valid;
	endproperty
	a_vec_answer: assert property (p_vec_answer)
		else $error("vector answer missing or stretched");

	// Vector code holds between answers
	property p_vec_hold;
		!vec_valid |-> $stable(vec);
	endproperty
	a_vec_hold: assert property (p_vec_hold)
		else $error("vector code moved without an answer");

	// The mask blocks every request
	property p_req_unmasked;
		irq_req |-> !imask;
	endproperty
	a_req_unmasked: assert property (p_req_unmasked)
		else $error("request raised while masked");

	// A fetch only follows a live request
	property p_fetch_cause;
		vec_fetch |-> $past(irq_req);
	endproperty
	a_fetch_cause: assert property (p_fetch_cause)
		else $error("vector fetch without a request");

	// Blanking lasts a single cycle
	property p_cfg_pulse;
		cfg_access |=> !cfg_access;
	endproperty
	a_cfg_pulse: assert property (p_cfg_pulse)
		else $error("configuration access longer than one cycle");

	// Main scenarios reached
	c_pop: cover property (cc_pop);
	c_fetch: cover property (vec_valid);
	c_cfg: cover property (cfg_access);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Testbench: controller and CPU end joined through the link interface
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import irq_pkg::*;
	logic       core_clk_i  = 1'b0;  // 125 MHz core clock
	logic       resetn_i    = 1'b0;  // Sync reset, active low
	src_mask_t  pin_i       = 4'h0;  // External pins
	logic       cmd_valid_i = 1'b0;  // Command offered
	logic [2:0] cmd_op_i    = 3'h0;  // Command code
	src_sel_t   cmd_sel_i   = 2'h0;  // Source index
	src_mask_t  cmd_data_i  = 4'h0;  // Enable mask
	logic       nest_i      = 1'b0;  // Nested mode, on for the masked pass
	logic       cmd_ready_o, done_o, missed_o, svc_o, reset_fetch_o;
	logic       imask_o, sema_o, unwanted_reset_o;
	src_sel_t   svc_src_o;           // Serviced source
	src_mask_t  pending_o;           // Pending flags
	int         bad_count   = 0;     // Mismatches
	int         checks_done = 0;     // Comparisons
	int         svc_n = 0, miss_n = 0, fetch_n = 0, spur_n = 0;
	int         s0, m0;

	// Free-running clock
	always #4 core_clk_i = ~core_clk_i;

	irq_link_if irq_link_if_inst ();
	// Priorities and edge sense fixed; all pins rising-edge
	irq_dev_end irq_dev_end_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.link(irq_link_if_inst), .pin_i(pin_i), .rise_i(4'hF), .prio_i(8'h1B),
		.nest_i(nest_i), .unwanted_reset_o(unwanted_reset_o), .pending_o(pending_o));
	irq_cpu_end irq_cpu_end_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.link(irq_link_if_inst), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
		.cmd_sel_i(cmd_sel_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
		.done_o(done_o), .missed_o(missed_o), .svc_o(svc_o), .svc_src_o(svc_src_o),
		.reset_fetch_o(reset_fetch_o), .imask_o(imask_o), .sema_o(sema_o));
	irq_link_chk irq_link_chk_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.cfg_access(irq_link_if_inst.cfg_access), .flag_clr(irq_link_if_inst.flag_clr),
		.imask(irq_link_if_inst.imask), .cc_pop(irq_link_if_inst.cc_pop),
		.vec_fetch(irq_link_if_inst.vec_fetch), .irq_req(irq_link_if_inst.irq_req),
		.vec_valid(irq_link_if_inst.vec_valid), .vec(irq_link_if_inst.vec),
		.spur_reset(irq_link_if_inst.spur_reset));

	// Pulse counters, sampled mid-cycle where outputs are settled
	always @(negedge core_clk_i) begin
		if (resetn_i === 1'b1) begin
			svc_n   += (svc_o === 1'b1);
			miss_n  += (missed_o === 1'b1);
			fetch_n += (reset_fetch_o === 1'b1);
			spur_n  += (unwanted_reset_o === 1'b1);
		end
	end

	// Verdict and end of run
	task automatic close_out();
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One comparison, reported at once on mismatch
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// Offer a command, hold it until taken, then wait for its done pulse
	task automatic do_cmd(input logic [2:0] op, input src_sel_t sel, input src_mask_t d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		cmd_valid_i <= 1'b1;
		cmd_op_i    <= op;
		cmd_sel_i   <= sel;
		cmd_data_i  <= d;
		// Ready is combinational; a high value mid-cycle means taken at the next edge
		do begin
			@(negedge core_clk_i);
			n++;
		end while (cmd_ready_o !== 1'b1 && n < 300);
		@(posedge core_clk_i);
		cmd_valid_i <= 1'b0;
		do begin
			@(negedge core_clk_i);
			n++;
		end while (done_o !== 1'b1 && n < 600);
		check("cmd_done", 8'h1, 8'(done_o));
	endtask

	// Hang guard, well above the expected run length
	initial begin
		repeat (20000) @(posedge core_clk_i);
		bad_count++;
		close_out();
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		@(negedge core_clk_i);
		check("imask_rst", 8'(IMASK_RST), 8'(imask_o));
		check("pend_rst", 8'h00, 8'(pending_o));
		do_cmd(OP_RIM, 2'h0, 4'h0);
		check("imask_rim", 8'h00, 8'(imask_o));
		do_cmd(OP_SIM, 2'h0, 4'h0);
		check("imask_sim", 8'h01, 8'(imask_o));
		// Edge on a disabled source latches its flag
		@(posedge core_clk_i);
		pin_i <= 4'h2;
		repeat (5) @(negedge core_clk_i);
		check("pend_latch", 8'h02, 8'(pending_o));
		do_cmd(OP_RIM, 2'h0, 4'h0);
		// Enable mask cleared while the flag stays up: never a reset
		do_cmd(OP_EN, 2'h0, 4'h0);
		do_cmd(OP_CLR, 2'h1, 4'h0);
		check("pend_clr", 8'h00, 8'(pending_o));
		check("spur_none", 8'h00, 8'(spur_n));
		do_cmd(OP_EN, 2'h0, 4'h1);
		// Slide a pin edge across a configuration write, masked and unmasked
		for (int m = 0; m < 2; m++) begin
			for (int k = 0; k < 8; k++) begin
				if (m == 1) begin
					// Nested mode must not change a single-source outcome
					nest_i <= 1'b1;
					do_cmd(OP_SIM, 2'h0, 4'h0);
				end
				s0 = svc_n;
				m0 = miss_n;
				fork
					begin
						// Pin moves on a rising edge, never mid-cycle
						repeat (k + 1) @(posedge core_clk_i);
						pin_i <= 4'h3;
					end
					begin
						repeat (3) @(posedge core_clk_i);
						do_cmd(OP_CFG, 2'h0, 4'h0);
					end
				join
				repeat (40) @(negedge core_clk_i);
				// Serviced once: by hardware or by the software call, never both
				check("svc_once", 8'h01, 8'(svc_n - s0 <= 1 && svc_n - s0 + miss_n - m0 >= 1));
				check("miss_le1", 8'h01, 8'(miss_n - m0 <= 1));
				check("svc_src", 8'h00, 8'(svc_src_o));
				check("sema_end", 8'h00, 8'(sema_o));
				check("imask_end", 8'h00, 8'(imask_o));
				check("pend_end", 8'h00, 8'(pending_o));
				@(posedge core_clk_i);
				pin_i <= 4'h2;
				repeat (4) @(posedge core_clk_i);
			end
		end
		// Some offset must have landed in the blanked cycle
		check("missed_seen", 8'h01, 8'(miss_n > 0));
		check("no_rst_vec", 8'h00, 8'(fetch_n));
		check("spur_end", 8'h00, 8'(spur_n));
		close_out();
	end
endmodule
`default_nettype wire
